//--- common/sdcmd_if.sv
// Command link between the memory controller and the DRAM command logic.
// Both ends share clock_i; only the controller drives the data pins, reads are not carried.
`timescale 1ns/10ps
`default_nettype none
interface sdcmd_if;
   logic sel_n;
   logic row_strobe_n;
   logic col_strobe_n;
   logic store_strobe_n;
   logic [11:0] addr;
   logic bank_sel_high;
   logic bank_sel_low;
   logic [15:0] dq_out;
   logic dq_oe;
   modport ctrl (output sel_n, row_strobe_n, col_strobe_n, store_strobe_n, addr, bank_sel_high,
                 bank_sel_low, dq_out, dq_oe);
   modport dev (input sel_n, row_strobe_n, col_strobe_n, store_strobe_n, addr, bank_sel_high,
                bank_sel_low, dq_out, dq_oe);
endinterface
`default_nettype wire

//--- common/sdcmd_pkg.sv
// Constants, command codes, field layouts and decoding shared by both ends of the DRAM command link.
// Assumes one 20 MHz clock for both ends; all times are turned into whole cycles here.
package sdcmd_pkg;
   localparam int CLK_NS = 50;
   localparam int PWRUP_US = 200;
   localparam int PWRUP_CYC = PWRUP_US * 1000 / CLK_NS;
   localparam int CLOSE_IDLE_NS = 20;
   localparam int CLOSE_IDLE_CYC = (CLOSE_IDLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int MODE_GAP_CYC = 2;
   localparam int REFRESH_CYCLE_NS = 70;
   localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int OPEN_COL_NS = 20;
   localparam int OPEN_COL_CYC = (OPEN_COL_NS + CLK_NS - 1) / CLK_NS;
   localparam int ROW_OPEN_NS = 50;
   localparam int ROW_OPEN_CYC = (ROW_OPEN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RETENTION_MS = 64;
   localparam int RETENTION_CYC = RETENTION_MS * 1000000 / CLK_NS;
   localparam int REFRESH_COUNT = 4096;
   localparam int INIT_REFRESHES = 2;
   // Command codes as {select, row strobe, column strobe, store strobe}, all active low.
   localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_CLOSE = 4'h2;
   localparam logic [3:0] CMD_OPEN_ROW = 4'h3;
   localparam logic [3:0] CMD_STORE = 4'h4;
   localparam logic [3:0] CMD_STOP = 4'h6;
   localparam logic [3:0] CMD_IDLE = 4'h7;
   // Operating-mode and drive-mode fields.
   localparam int OM_COUNT_LSB = 0;
   localparam int OM_ORDER_BIT = 3;
   localparam int OM_LAT_LSB = 4;
   localparam int OM_POLICY_BIT = 9;
   localparam int DM_STRENGTH_LSB = 5;
   localparam int AUTO_CLOSE_BIT = 10;
   localparam logic [2:0] LAT_CODE_2 = 3'h2;
   localparam logic [2:0] LAT_CODE_3 = 3'h3;
   localparam logic [2:0] COUNT_CODE_8 = 3'h3;
   localparam logic [2:0] COUNT_CODE_FULL = 3'h7;
   localparam logic [1:0] STRENGTH_FULL = 2'h0;
   localparam logic [1:0] STRENGTH_HALF = 2'h1;
   localparam logic [1:0] STRENGTH_RESV = 2'h2;
   localparam logic [1:0] STRENGTH_QUARTER = 2'h3;
   localparam logic [11:0] OM_MUST_ZERO = 12'hd80;
   // Controller register map.
   localparam logic [4:0] REG_MODE = 5'h00;
   localparam logic [4:0] REG_DRIVE = 5'h04;
   localparam logic [4:0] REG_TARGET = 5'h08;
   localparam logic [4:0] REG_DATA = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [11:0] REG_MODE_RST = 12'h023;
   localparam logic [2:0] REG_DRIVE_RST = 3'h0;

   // Beats in one store burst: single-word policy forces one.
   function automatic logic [8:0] burst_beats(input logic [11:0] om);
      if (om[OM_POLICY_BIT])
         return 9'h001;
      if (om[OM_COUNT_LSB +: 3] == COUNT_CODE_FULL)
         return 9'h100;
      return 9'(9'h001 << om[OM_COUNT_LSB +: 2]);
   endfunction

   function automatic logic mode_legal(input logic [11:0] om);
      logic [2:0] cnt;
      cnt = om[OM_COUNT_LSB +: 3];
      return (om[OM_LAT_LSB +: 3] == LAT_CODE_2 || om[OM_LAT_LSB +: 3] == LAT_CODE_3) &&
             (cnt <= COUNT_CODE_8 || (cnt == COUNT_CODE_FULL && !om[OM_ORDER_BIT])) &&
             ((om & OM_MUST_ZERO) == 12'h000);
   endfunction
endpackage

//--- core/sdcmd_burst_col.sv
// Column of one beat within a burst, from the start column, beat index and programmed order.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module sdcmd_burst_col (
   // Burst description
   input wire logic [7:0] start_i,
   input wire logic [7:0] beat_i,
   input wire logic interleave_i,
   input wire logic [2:0] count_code_i,
   // Result
   output logic [7:0] col_o
);
   logic [7:0] mask;

   always_comb begin
      if (count_code_i == sdcmd_pkg::COUNT_CODE_FULL)
         mask = 8'hff;
      else
         mask = 8'((8'h01 << count_code_i[1:0]) - 8'h01);
      if (interleave_i)
         col_o = (start_i & ~mask) | ((start_i ^ beat_i) & mask);
      else
         col_o = (start_i & ~mask) | (8'(start_i + beat_i) & mask);
   end
endmodule
`default_nettype wire

//--- core/sdcmd_ctrl.sv
// Memory controller end: power-up initialisation, periodic refresh and store bursts on request.
// Software reaches its registers over a plain strobe port; read data follow one cycle later.
//
// Behaviour
// - 4096 refreshes within every retention period
// - Idle commands for 200 us after start
// - Close all banks, then wait close time
// - Load operating mode, wait gap; drive optional
// - Two or more refreshes, each with cycle time
// - Mode, drive and refresh order is free
// - Program operating mode before any store
// - Operating load: strobes low, bank pins zero
// - Drive load: A12 high, A13 low
// - Latency and store policy fields in mode
// - Order and count fields; no reserved codes
// - Operating load drives unused bits zero
// - Drive strength field; default full
// - Drive load: only A5, A6 may be set
// - Burst columns wrap within the burst block
// - Interleaved burst columns use exclusive-or
// - Bank pins select one of four banks
// - Open row, wait open-to-column delay
// - Close one bank after row-open time
// - Auto-close bit high closes every bank
// - Store carries column and first data word
// - Store input ends after programmed burst count
// - Refresh only while all banks idle
`timescale 1ns/10ps
`default_nettype none
module sdcmd_ctrl #(
   parameter int RETENTION_CYC = sdcmd_pkg::RETENTION_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [4:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Link
   sdcmd_if.ctrl link
);
   localparam logic [15:0] REF_GAP = 16'(RETENTION_CYC / sdcmd_pkg::REFRESH_COUNT);

   typedef enum logic [3:0] {
      S_WAIT, S_CLOSE_ALL, S_MODE, S_DRIVE, S_REF, S_IDLE, S_OPEN, S_STORE, S_BURST, S_FIN
   } sdcmd_st_t;

   typedef struct packed {
      sdcmd_st_t st;
      sdcmd_st_t ret;
      logic [11:0] cnt;
      logic [1:0] nref;
      logic done;
      logic pend;
      logic cfg_bad;
      logic ref_due;
      logic [15:0] rcnt;
      logic [11:0] om;
      logic [2:0] drv;
      logic [22:0] tgt;
      logic [15:0] data;
      logic [8:0] left;
      logic [7:0] beat;
      logic [3:0] cmd;
      logic [11:0] addr;
      logic bhi;
      logic blo;
      logic [15:0] dq;
      logic oe;
      logic [31:0] rdata;
   } sdcmd_ctl_t;

   localparam sdcmd_ctl_t RST = '{
      st: S_WAIT, ret: S_CLOSE_ALL, cnt: 12'(sdcmd_pkg::PWRUP_CYC - 2), nref: 2'h0, done: 1'b0,
      pend: 1'b0, cfg_bad: 1'b0, ref_due: 1'b0, rcnt: 16'h0000, om: sdcmd_pkg::REG_MODE_RST,
      drv: sdcmd_pkg::REG_DRIVE_RST, tgt: 23'h000000, data: 16'h0000, left: 9'h000,
      beat: 8'h00, cmd: sdcmd_pkg::CMD_IDLE, addr: 12'h000, bhi: 1'b0, blo: 1'b0,
      dq: 16'h0000, oe: 1'b0, rdata: 32'h00000000};

   sdcmd_ctl_t q, n;
   logic [8:0] beats;

   assign beats = sdcmd_pkg::burst_beats(q.om);

   // Holds idle commands for gap cycles counted from the command just issued.
   function automatic sdcmd_ctl_t hold(input sdcmd_ctl_t s, input int gap, input sdcmd_st_t ret);
      hold = s;
      if (gap <= 1)
         hold.st = ret;
      else begin
         hold.st = S_WAIT;
         hold.cnt = 12'(gap - 2);
         hold.ret = ret;
      end
   endfunction

   always_comb begin
      n = q;
      n.cmd = sdcmd_pkg::CMD_IDLE;
      n.addr = 12'h000;
      n.bhi = 1'b0;
      n.blo = 1'b0;
      n.oe = 1'b0;
      // Refresh pacing runs from reset; a due refresh waits for the idle state.
      if (q.rcnt == 16'h0000) begin
         n.rcnt = REF_GAP - 16'h0001;
         n.ref_due = 1'b1;
      end else
         n.rcnt = q.rcnt - 16'h0001;
      unique case (q.st)
         S_WAIT: begin
            n.cnt = q.cnt - 12'h001;
            if (q.cnt == 12'h000)
               n.st = q.ret;
         end
         S_CLOSE_ALL: begin
            n.cmd = sdcmd_pkg::CMD_CLOSE;
            n.addr[sdcmd_pkg::AUTO_CLOSE_BIT] = 1'b1;
            n = hold(n, sdcmd_pkg::CLOSE_IDLE_CYC, S_MODE);
         end
         S_MODE: begin
            n.cmd = sdcmd_pkg::CMD_LOAD_MODE;
            n.addr = q.om;
            n = hold(n, sdcmd_pkg::MODE_GAP_CYC, q.drv[0] ? S_DRIVE : S_REF);
         end
         S_DRIVE: begin
            n.cmd = sdcmd_pkg::CMD_LOAD_MODE;
            n.bhi = 1'b1;
            n.addr[sdcmd_pkg::DM_STRENGTH_LSB +: 2] = q.drv[2:1];
            n = hold(n, sdcmd_pkg::MODE_GAP_CYC, S_REF);
         end
         S_REF: begin
            n.cmd = sdcmd_pkg::CMD_REFRESH;
            // A refresh falling due in this very cycle stays pending.
            if (q.rcnt != 16'h0000)
               n.ref_due = 1'b0;
            if (!q.done && q.nref != 2'(sdcmd_pkg::INIT_REFRESHES - 1)) begin
               n.nref = q.nref + 2'h1;
               n = hold(n, sdcmd_pkg::REFRESH_CYCLE_CYC, S_REF);
            end else begin
               n.done = 1'b1;
               n = hold(n, sdcmd_pkg::REFRESH_CYCLE_CYC, S_IDLE);
            end
         end
         S_IDLE: begin
            if (q.ref_due)
               n.st = S_REF;
            else if (q.pend)
               n.st = S_OPEN;
         end
         S_OPEN: begin
            n.pend = 1'b0;
            n.cmd = sdcmd_pkg::CMD_OPEN_ROW;
            n.addr = q.tgt[19:8];
            {n.bhi, n.blo} = q.tgt[21:20];
            n = hold(n, sdcmd_pkg::OPEN_COL_CYC, S_STORE);
         end
         S_STORE: begin
            n.cmd = sdcmd_pkg::CMD_STORE;
            n.addr[7:0] = q.tgt[7:0];
            n.addr[sdcmd_pkg::AUTO_CLOSE_BIT] = q.tgt[22];
            {n.bhi, n.blo} = q.tgt[21:20];
            n.dq = q.data;
            n.oe = 1'b1;
            n.beat = 8'h01;
            n.left = beats - 9'h001;
            n.st = (beats == 9'h001) ? S_FIN : S_BURST;
         end
         S_BURST: begin
            n.dq = q.data + {8'h00, q.beat};
            n.oe = 1'b1;
            n.beat = q.beat + 8'h01;
            n.left = q.left - 9'h001;
            if (q.left == 9'h001)
               n.st = S_FIN;
         end
         S_FIN: begin
            if (q.tgt[22])
               n = hold(n, sdcmd_pkg::ROW_OPEN_CYC + sdcmd_pkg::CLOSE_IDLE_CYC, S_IDLE);
            else begin
               n.cmd = sdcmd_pkg::CMD_CLOSE;
               {n.bhi, n.blo} = q.tgt[21:20];
               n = hold(n, sdcmd_pkg::CLOSE_IDLE_CYC, S_IDLE);
            end
         end
         default: n.st = S_IDLE;
      endcase
      // Register port; a software request set in the cycle it is taken still stands.
      if (reg_wr_i) begin
         case (reg_addr_i)
            sdcmd_pkg::REG_MODE: begin
               if (sdcmd_pkg::mode_legal(reg_wdata_i[11:0]))
                  n.om = reg_wdata_i[11:0];
               else
                  n.cfg_bad = 1'b1;
            end
            sdcmd_pkg::REG_DRIVE: begin
               if (reg_wdata_i[2:1] != sdcmd_pkg::STRENGTH_RESV)
                  n.drv = reg_wdata_i[2:0];
               else
                  n.cfg_bad = 1'b1;
            end
            sdcmd_pkg::REG_TARGET: n.tgt = reg_wdata_i[22:0];
            sdcmd_pkg::REG_DATA: begin
               n.data = reg_wdata_i[15:0];
               n.pend = 1'b1;
            end
            default: begin
            end
         endcase
      end
      n.rdata = 32'h00000000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            sdcmd_pkg::REG_MODE: n.rdata = {20'h00000, q.om};
            sdcmd_pkg::REG_DRIVE: n.rdata = {29'h00000000, q.drv};
            sdcmd_pkg::REG_TARGET: n.rdata = {9'h000, q.tgt};
            sdcmd_pkg::REG_DATA: n.rdata = {16'h0000, q.data};
            sdcmd_pkg::REG_STATUS:
               n.rdata = {24'h000000, 4'(q.st), q.cfg_bad, q.pend || q.st != S_IDLE, q.pend, q.done};
            default: n.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= RST;
      end else begin
         q <= n;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign {link.sel_n, link.row_strobe_n, link.col_strobe_n, link.store_strobe_n} = q.cmd;
   assign link.addr = q.addr;
   assign link.bank_sel_high = q.bhi;
   assign link.bank_sel_low = q.blo;
   assign link.dq_out = q.dq;
   assign link.dq_oe = q.oe;
endmodule
`default_nettype wire

//--- core/sdcmd_device.sv
// DRAM command logic: decodes commands, holds the mode settings, bank states and store bursts.
// Assumes the controller keeps all timing gaps; it flags commands illegal for the bank state, stores before a mode load and loads with bad bank pins.
`timescale 1ns/10ps
`default_nettype none
module sdcmd_device (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Link
   sdcmd_if.dev link,
   // Array store port
   output logic store_o,
   output logic [1:0] store_bank_o,
   output logic [11:0] store_row_o,
   output logic [7:0] store_col_o,
   output logic [15:0] store_data_o,
   // Settings and state
   output logic mode_loaded_o,
   output logic [1:0] read_latency_o,
   output logic burst_order_o,
   output logic [2:0] burst_count_o,
   output logic store_burst_policy_o,
   output logic [1:0] drive_strength_o,
   output logic [3:0] bank_open_o,
   output logic illegal_o
);
   typedef struct packed {
      logic [11:0] om;
      logic [13:0] dm;
      logic om_ok;
      logic [1:0] lat;
      logic [3:0] open;
      logic [3:0][11:0] row;
      logic busy;
      logic aclose;
      logic [1:0] bank;
      logic [7:0] col0;
      logic [8:0] left;
      logic [7:0] beat;
      logic st;
      logic [1:0] st_bank;
      logic [11:0] st_row;
      logic [7:0] st_col;
      logic [15:0] st_dat;
      logic bad;
   } sdcmd_dev_t;

   sdcmd_dev_t q, n;
   logic [3:0] cmd;
   logic [1:0] b;
   logic is_store;
   logic [7:0] col;
   logic [8:0] beats;

   assign cmd = {link.sel_n, link.row_strobe_n, link.col_strobe_n, link.store_strobe_n};
   assign b = {link.bank_sel_high, link.bank_sel_low};
   assign is_store = (cmd == sdcmd_pkg::CMD_STORE);
   assign beats = sdcmd_pkg::burst_beats(q.om);

   sdcmd_burst_col u_col (
      .start_i(is_store ? link.addr[7:0] : q.col0),
      .beat_i(is_store ? 8'h00 : q.beat),
      .interleave_i(q.om[sdcmd_pkg::OM_ORDER_BIT]),
      .count_code_i(q.om[sdcmd_pkg::OM_COUNT_LSB +: 3]),
      .col_o(col)
   );

   always_comb begin
      n = q;
      n.st = 1'b0;
      n.bad = 1'b0;
      if (q.busy) begin
         n.st = 1'b1;
         n.st_bank = q.bank;
         n.st_row = q.row[q.bank];
         n.st_col = col;
         n.st_dat = link.dq_out;
         n.beat = q.beat + 8'h01;
         n.left = q.left - 9'h001;
         if (q.left == 9'h001) begin
            n.busy = 1'b0;
            if (q.aclose)
               n.open[q.bank] = 1'b0;
         end
      end
      case (cmd)
         sdcmd_pkg::CMD_LOAD_MODE: begin
            if (q.open != 4'h0)
               n.bad = 1'b1;
            else if (b == 2'b00) begin
               n.om = link.addr;
               n.om_ok = 1'b1;
               if (link.addr[sdcmd_pkg::OM_LAT_LSB +: 3] == sdcmd_pkg::LAT_CODE_2)
                  n.lat = 2'h2;
               else if (link.addr[sdcmd_pkg::OM_LAT_LSB +: 3] == sdcmd_pkg::LAT_CODE_3)
                  n.lat = 2'h3;
               else
                  n.lat = 2'h0;
            end else if (b == 2'b10)
               n.dm = {link.bank_sel_low, link.bank_sel_high, link.addr};
            else
               n.bad = 1'b1;
         end
         sdcmd_pkg::CMD_OPEN_ROW: begin
            if (q.open[b])
               n.bad = 1'b1;
            else begin
               n.open[b] = 1'b1;
               n.row[b] = link.addr;
            end
         end
         sdcmd_pkg::CMD_CLOSE: begin
            if (link.addr[sdcmd_pkg::AUTO_CLOSE_BIT]) begin
               n.open = 4'h0;
               n.busy = 1'b0;
               n.st = 1'b0;
            end else begin
               n.open[b] = 1'b0;
               if (q.busy && q.bank == b) begin
                  n.busy = 1'b0;
                  n.st = 1'b0;
               end
            end
         end
         sdcmd_pkg::CMD_STORE: begin
            if (!q.open[b] || !q.om_ok)
               n.bad = 1'b1;
            else begin
               if (q.busy && q.aclose && q.bank != b)
                  n.open[q.bank] = 1'b0;
               n.st = 1'b1;
               n.st_bank = b;
               n.st_row = q.row[b];
               n.st_col = col;
               n.st_dat = link.dq_out;
               n.bank = b;
               n.col0 = link.addr[7:0];
               n.aclose = link.addr[sdcmd_pkg::AUTO_CLOSE_BIT];
               n.beat = 8'h01;
               n.left = beats - 9'h001;
               n.busy = (beats != 9'h001);
               if (beats == 9'h001 && link.addr[sdcmd_pkg::AUTO_CLOSE_BIT])
                  n.open[b] = 1'b0;
            end
         end
         sdcmd_pkg::CMD_STOP: begin
            n.busy = 1'b0;
            n.st = 1'b0;
         end
         sdcmd_pkg::CMD_REFRESH: begin
            if (q.open != 4'h0)
               n.bad = 1'b1;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign store_o = q.st;
   assign store_bank_o = q.st_bank;
   assign store_row_o = q.st_row;
   assign store_col_o = q.st_col;
   assign store_data_o = q.st_dat;
   assign mode_loaded_o = q.om_ok;
   assign read_latency_o = q.lat;
   assign burst_order_o = q.om[sdcmd_pkg::OM_ORDER_BIT];
   assign burst_count_o = q.om[sdcmd_pkg::OM_COUNT_LSB +: 3];
   assign store_burst_policy_o = q.om[sdcmd_pkg::OM_POLICY_BIT];
   assign drive_strength_o = q.dm[sdcmd_pkg::DM_STRENGTH_LSB +: 2];
   assign bank_open_o = q.open;
   assign illegal_o = q.bad;
endmodule
`default_nettype wire

//--- test/sdcmd_monitor.sv
// Checker of the command link between the controller end and the command logic end.
// Sits beside the link instance and sees its signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module sdcmd_monitor #(
   parameter int RETENTION_CYC = sdcmd_pkg::RETENTION_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // Link
   input wire logic sel_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic store_strobe_n,
   input wire logic [11:0] addr,
   input wire logic bank_sel_high,
   input wire logic bank_sel_low,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe
);
   // A refresh may wait behind one full-page burst.
   localparam int REF_LIM = RETENTION_CYC / 4096 + 300;
   logic [3:0] cmd;
   logic [12:0] up_r;
   logic [15:0] gap_r;
   logic seen_r;
   logic ref_r;
   assign cmd = {sel_n, row_strobe_n, col_strobe_n, store_strobe_n};
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up_r <= 13'h0000;
         gap_r <= 16'h0000;
         seen_r <= 1'b0;
         ref_r <= 1'b0;
      end else begin
         up_r <= (up_r < 13'h0fa0) ? up_r + 13'h0001 : up_r;
         seen_r <= seen_r | (cmd != 4'h7);
         ref_r <= ref_r | (cmd == 4'h1);
         gap_r <= (cmd == 4'h1) ? 16'h0000 : gap_r + 16'h0001;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_open; cmd == 4'h3; endsequence
   sequence s_store; cmd == 4'h4 && dq_oe; endsequence
   property p_pwrup_idle; up_r < 13'h0f9f |-> cmd == 4'h7; endproperty
   a_pwrup_idle: assert property (p_pwrup_idle) else $error("command in power-up wait");
   property p_first_close; !seen_r && cmd != 4'h7 |-> cmd == 4'h2 && addr[10]; endproperty
   a_first_close: assert property (p_first_close) else $error("first command not close-all");
   property p_load_gap; cmd == 4'h0 |=> cmd == 4'h7; endproperty
   a_load_gap: assert property (p_load_gap) else $error("mode load gap short");
   property p_refresh_gap; cmd == 4'h1 |=> cmd == 4'h7; endproperty
   a_refresh_gap: assert property (p_refresh_gap) else $error("refresh cycle time short");
   property p_om_fields; cmd == 4'h0 && !bank_sel_high |-> !bank_sel_low && (addr & 12'hd80) == 12'h000
      && addr[6:5] == 2'h1 && (addr[2:0] <= 3'h3 || (addr[2:0] == 3'h7 && !addr[3])); endproperty
   a_om_fields: assert property (p_om_fields) else $error("bad operating load");
   property p_dm_fields; cmd == 4'h0 && bank_sel_high |-> !bank_sel_low && (addr & 12'hf9f) == 12'h000
      && addr[6:5] != 2'h2; endproperty
   a_dm_fields: assert property (p_dm_fields) else $error("bad drive load");
   property p_open_store; s_open |=> s_store ##0 $stable({bank_sel_high, bank_sel_low}); endproperty
   a_open_store: assert property (p_open_store) else $error("open not followed by store");
   property p_close_after; cmd == 4'h2 && !addr[10] |-> $past(dq_oe) && !dq_oe; endproperty
   a_close_after: assert property (p_close_after) else $error("close not at burst end");
   property p_refresh_rate; ref_r |-> gap_r < REF_LIM; endproperty
   a_refresh_rate: assert property (p_refresh_rate) else $error("refresh too late");
endmodule
`default_nettype wire

//--- test/sdcmd_tb_top.sv
// Testbench: both link ends joined and driven through the controller's register port.
// Assumes package, link, design modules and monitor are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module sdcmd_tb_top;
   localparam int RET = 4096 * 64;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [4:0] reg_addr_i = 5'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic store_o, mode_loaded_o, burst_order_o, store_burst_policy_o, illegal_o;
   logic [1:0] store_bank_o, read_latency_o, drive_strength_o;
   logic [11:0] store_row_o;
   logic [7:0] store_col_o;
   logic [15:0] store_data_o;
   logic [2:0] burst_count_o;
   logic [3:0] bank_open_o;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   sdcmd_if link();
   sdcmd_ctrl #(.RETENTION_CYC(RET)) u_sdcmd_ctrl (.clock_i(clock_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .link(link.ctrl));
   sdcmd_device u_sdcmd_device (.clock_i(clock_i), .nrst_i(nrst_i), .link(link.dev), .store_o(store_o),
      .store_bank_o(store_bank_o), .store_row_o(store_row_o), .store_col_o(store_col_o),
      .store_data_o(store_data_o), .mode_loaded_o(mode_loaded_o), .read_latency_o(read_latency_o),
      .burst_order_o(burst_order_o), .burst_count_o(burst_count_o), .store_burst_policy_o(store_burst_policy_o),
      .drive_strength_o(drive_strength_o), .bank_open_o(bank_open_o), .illegal_o(illegal_o));
   sdcmd_monitor #(.RETENTION_CYC(RET)) u_sdcmd_monitor (.clock_i(clock_i), .nrst_i(nrst_i), .sel_n(link.sel_n),
      .row_strobe_n(link.row_strobe_n), .col_strobe_n(link.col_strobe_n), .store_strobe_n(link.store_strobe_n),
      .addr(link.addr), .bank_sel_high(link.bank_sel_high), .bank_sel_low(link.bank_sel_low),
      .dq_out(link.dq_out), .dq_oe(link.dq_oe));
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One register cycle; the read data are taken in the cycle after the strobe.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= wd;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic do_reset();
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (10) @(posedge clock_i);
      nrst_i <= 1'b1;
   endtask
   task automatic sc_regs();
      logic [31:0] d;
      do_reset();
      bus(1'b1, 5'h00, 32'h0a3, d);
      bus(1'b1, 5'h00, 32'h043, d);
      bus(1'b0, 5'h00, 32'h0, d);
      chk("mode kept", d, 32'(sdcmd_pkg::REG_MODE_RST));
      bus(1'b0, 5'h10, 32'h0, d);
      chk("rejected", 32'(d[3]), 32'h1);
      bus(1'b1, 5'h04, 32'h5, d);
      bus(1'b0, 5'h04, 32'h0, d);
      chk("drive kept", d, 32'(sdcmd_pkg::REG_DRIVE_RST));
      bus(1'b0, 5'h14, 32'h0, d);
      chk("unmapped", d, 32'h0);
   endtask
   task automatic sc_init(input logic [11:0] om, input logic [2:0] dm);
      logic [31:0] d;
      do_reset();
      bus(1'b1, 5'h00, 32'(om), d);
      bus(1'b1, 5'h04, 32'(dm), d);
      chk("early load", 32'(mode_loaded_o), 32'h0);
      d = 32'h0;
      for (int i = 0; i < 5000 && d[0] !== 1'b1; i++)
         bus(1'b0, 5'h10, 32'h0, d);
      chk("init done", 32'(d[0]), 32'h1);
      chk("loaded", 32'(mode_loaded_o), 32'h1);
      chk("latency", 32'(read_latency_o), om[5:4] == 2'h3 ? 32'h3 : 32'h2);
      chk("policy", 32'(store_burst_policy_o), 32'(om[9]));
      chk("order", 32'(burst_order_o), 32'(om[3]));
      chk("count", 32'(burst_count_o), 32'(om[2:0]));
      chk("strength", 32'(drive_strength_o), dm[0] ? 32'(dm[2:1]) : 32'h0);
   endtask
   task automatic sc_store(input logic [11:0] om, input logic [1:0] bk, input logic [11:0] row,
                           input logic [7:0] col, input logic ac);
      logic [31:0] d;
      logic [7:0] m;
      logic [7:0] c;
      int n;
      int t;
      n = om[9] ? 1 : (om[2:0] == 3'h7) ? 256 : 1 << om[1:0];
      m = 8'(n - 1);
      bus(1'b1, 5'h08, {9'h000, ac, bk, row, col}, d);
      bus(1'b1, 5'h0c, 32'h0000c350, d);
      for (int k = 0; k < n; k++) begin
         t = 0;
         do begin
            @(posedge clock_i);
            #1 t++;
         end while (store_o !== 1'b1 && t < 600);
         c = ((om[3] ? col ^ 8'(k) : col + 8'(k)) & m) | (col & ~m);
         chk("beat seen", 32'(store_o), 32'h1);
         if (k == 0)
            chk("open", 32'(bank_open_o), 32'(4'h1 << bk));
         chk("place", 32'({store_bank_o, store_row_o}), 32'({bk, row}));
         chk("col", 32'(store_col_o), 32'(c));
         chk("data", 32'(store_data_o), 32'h0000c350 + 32'(k));
      end
      repeat (4) begin
         @(posedge clock_i);
         #1 chk("beat past count", 32'({store_o, illegal_o}), 32'h0);
      end
      chk("closed", 32'(bank_open_o), 32'h0);
   endtask
   initial begin
      sc_regs();
      sc_init(12'h022, 3'h3);
      sc_store(12'h022, 2'h1, 12'h005, 8'h06, 1'b0);
      sc_store(12'h022, 2'h0, 12'hfff, 8'h03, 1'b1);
      sc_init(12'h03b, 3'h0);
      sc_store(12'h03b, 2'h2, 12'h7a1, 8'h11, 1'b1);
      sc_init(12'h027, 3'h7);
      sc_store(12'h027, 2'h3, 12'h100, 8'hfe, 1'b0);
      sc_init(12'h231, 3'h1);
      sc_store(12'h231, 2'h3, 12'h001, 8'h81, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
